// ==== inc/ubff_pkg.sv ====
// Shared constants, types and filter taps of the upstream burst framer
package ubff_pkg;

  localparam int          UBFF_BYTE_W   = 8;
  localparam int          UBFF_CNT_W    = 16;
  localparam int          UBFF_SYM_W    = 3;
  localparam int          UBFF_COEF_W   = 10;
  localparam int          UBFF_TAPS     = 9;
  localparam int          UBFF_ROLLOFF_PCT = 25;
  localparam int          UBFF_SCR_W    = 15;
  localparam logic [7:0]  UBFF_MIN_INFO = 8'h10;
  localparam logic [7:0]  UBFF_ZERO     = 8'h00;
  localparam logic [3:0]  UBFF_BPS_QPSK = 4'h2;
  localparam logic [3:0]  UBFF_BPS_QAM  = 4'h4;
  localparam logic [3:0]  UBFF_BYTE_BITS = 4'h8;

  // Square-root raised cosine, two samples per symbol, roll-off UBFF_ROLLOFF_PCT
  localparam logic signed [UBFF_COEF_W-1:0] UBFF_SRRC_COEF [UBFF_TAPS] = '{
    10'sh019, -10'sh051, -10'sh01f, 10'sh12a, 10'sh1ff,
    10'sh12a, -10'sh01f, -10'sh051, 10'sh019};

  // Constellation levels
  localparam logic signed [UBFF_SYM_W-1:0] UBFF_LVL_P3 = 3'sh3;
  localparam logic signed [UBFF_SYM_W-1:0] UBFF_LVL_P2 = 3'sh2;
  localparam logic signed [UBFF_SYM_W-1:0] UBFF_LVL_P1 = 3'sh1;
  localparam logic signed [UBFF_SYM_W-1:0] UBFF_LVL_0  = 3'sh0;

  typedef enum logic {UBFF_MOD_QPSK = 1'b0, UBFF_MOD_QAM16 = 1'b1} ubff_mod_t;
  typedef enum logic {UBFF_CW_FIXED = 1'b0, UBFF_CW_SHORT = 1'b1} ubff_cwmode_t;

  typedef enum logic [2:0] {
    UBFF_ST_IDLE  = 3'h0,
    UBFF_ST_WAIT  = 3'h1,
    UBFF_ST_PRE   = 3'h3,
    UBFF_ST_PLAN  = 3'h2,
    UBFF_ST_INFO  = 3'h6,
    UBFF_ST_PAR   = 3'h7,
    UBFF_ST_DRAIN = 3'h5
  } ubff_state_t;

  typedef struct packed {
    logic         fec_en;
    ubff_cwmode_t cw_mode;
    ubff_mod_t    modul;
    logic [7:0]   k;
    logic [7:0]   parity;
    logic [7:0]   guard_sym;
    logic [7:0]   grant_ms;
    logic [7:0]   ms_bytes;
    logic [7:0]   preamble;
    logic [15:0]  launch;
  } ubff_cfg_t;

endpackage : ubff_pkg

// ==== logic/ubff_srrc.sv ====
// Spectral shaping FIR for the I and Q symbol streams
`timescale 1ns/10ps
module ubff_srrc #(
  parameter int TAPS   = ubff_pkg::UBFF_TAPS,
  parameter int IN_W   = ubff_pkg::UBFF_SYM_W,
  parameter int COEF_W = ubff_pkg::UBFF_COEF_W,
  parameter int OUT_W  = 16
)(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    in_valid,
  input  wire logic signed [IN_W-1:0]  in_i,
  input  wire logic signed [IN_W-1:0]  in_q,
  output logic signed [OUT_W-1:0]      out_i,
  output logic signed [OUT_W-1:0]      out_q,
  output logic                         out_valid
);
  import ubff_pkg::*;

  localparam int ACC_W = IN_W + COEF_W + $clog2(TAPS);

  generate
    if (TAPS != UBFF_TAPS || COEF_W != UBFF_COEF_W || OUT_W > ACC_W)
    begin : g_chk
      $error("ubff_srrc: unsupported parameters");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Delay line, products and running sums
  genvar g;
  generate
    for (g = 0; g < TAPS; g++)
    begin : g_tap
      logic signed [IN_W-1:0]  di_q;
      logic signed [IN_W-1:0]  dq_q;
      logic signed [ACC_W-1:0] si;
      logic signed [ACC_W-1:0] sq;
      wire logic signed [IN_W-1:0] prev_i = (g == 0) ? in_i : g_tap[(g == 0) ? 0 : g-1].di_q;
      wire logic signed [IN_W-1:0] prev_q = (g == 0) ? in_q : g_tap[(g == 0) ? 0 : g-1].dq_q;
      wire logic signed [ACC_W-1:0] pi = ACC_W'(di_q) * ACC_W'(UBFF_SRRC_COEF[g]);
      wire logic signed [ACC_W-1:0] pq = ACC_W'(dq_q) * ACC_W'(UBFF_SRRC_COEF[g]);
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          di_q <= '0;
          dq_q <= '0;
        end
        else if (in_valid)
        begin
          di_q <= prev_i;
          dq_q <= prev_q;
        end
      end
      if (g == 0)
      begin : g_first
        assign si = pi;
        assign sq = pq;
      end
      else
      begin : g_next
        assign si = g_tap[g-1].si + pi;
        assign sq = g_tap[g-1].sq + pq;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered output, one sample after each input
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_i     <= '0;
      out_q     <= '0;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        out_i <= g_tap[TAPS-1].si[OUT_W-1:0];
        out_q <= g_tap[TAPS-1].sq[OUT_W-1:0];
      end
    end
  end

endmodule : ubff_srrc

// ==== logic/ubff_framer.sv ====
// Upstream burst framer: blocking, codeword fill, scramble, preamble, map, shape
// Notes on behaviour
// - With coding on, exactly one mode: fixed codewords or shortened last codeword.
// - Every codeword carries at least sixteen information bytes.
// - Fixed mode zero-fills to k, then adds zero codewords while they fit.
// - Shortened mode encodes burst bytes in k-byte blocks until leftover.
// - Shortened last codeword has at least sixteen bytes; requester sizes grant.
// - Shortened mode zero-fills up to the end of the allocation.
// - Zero full codewords first, then one shortened zero codeword if room.
// - Fewer than sixteen bytes left after full codewords: no shortened codeword.
// - Order: block, encode, scramble, preamble, map, filter, modulate. Here parity bytes are zeros ahead of the scrambler and output stops at the filter.
// - Coding may be switched off; blocks pass with no parity bytes.
// - Map to QPSK or 16QAM and start each burst at its scheduled time.
// - Shaping filter is square-root raised cosine with roll-off 0.25.
`timescale 1ns/10ps
module ubff_framer #(
  parameter int                           SYM_DIV  = 16,
  parameter logic [ubff_pkg::UBFF_SCR_W-1:0] SCR_SEED = 15'h0001,
  parameter logic [ubff_pkg::UBFF_SCR_W-1:0] SCR_TAPS = 15'h6000,
  parameter logic [7:0]                   PRE_BYTE = 8'hcc,
  parameter int                           OUT_W    = 16
)(
  input  wire logic               REF_CLK,
  input  wire logic               NRST,
  input  wire ubff_pkg::ubff_cfg_t CFG,
  input  wire logic               CFG_VALID,
  output logic                    CFG_READY,
  output logic                    CFG_ERR,
  input  wire logic [7:0]         S_DATA,
  input  wire logic               S_VALID,
  input  wire logic               S_LAST,
  output logic                    S_READY,
  output logic signed [OUT_W-1:0] TX_I,
  output logic signed [OUT_W-1:0] TX_Q,
  output logic                    TX_VALID,
  output logic                    TX_ON,
  output logic                    UNDERRUN,
  output logic                    OVERRUN
);
  import ubff_pkg::*;

  localparam int DIV_W = $clog2(SYM_DIV);
  localparam logic [DIV_W-1:0] HALF_M1 = DIV_W'(SYM_DIV / 2 - 1);

  generate
    if (SYM_DIV < 4 || (SYM_DIV % 2) != 0)
    begin : g_chk
      $error("ubff_framer: SYM_DIV must be even and at least 4");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_q;
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  wire logic rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sample and symbol enables, symbol time
  logic [DIV_W-1:0]      div_q;
  logic                  ph_q;
  logic [UBFF_CNT_W-1:0] sym_cnt_q;
  wire logic sample_en = (div_q == HALF_M1);
  wire logic sym_en    = sample_en & ~ph_q;

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q     <= '0;
      ph_q      <= 1'b0;
      sym_cnt_q <= '0;
    end
    else
    begin
      div_q <= sample_en ? '0 : div_q + 1'b1;
      if (sample_en)
        ph_q <= ~ph_q;
      if (sym_en)
        sym_cnt_q <= sym_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and burst registers
  ubff_state_t           st_q;
  ubff_state_t           st_d;
  ubff_cfg_t             cfg_q;
  logic [UBFF_CNT_W-1:0] rem_q;
  logic [7:0]            left_q;
  logic                  done_q;
  logic [UBFF_SCR_W-1:0] scr_q;
  logic [7:0]            sh_q;
  logic [3:0]            bl_q;

  // Grant capacity in bytes, minus guard time and preamble
  wire logic [UBFF_CNT_W-1:0] grant_b = UBFF_CNT_W'(CFG.grant_ms) * UBFF_CNT_W'(CFG.ms_bytes);
  wire logic [8:0] guard_b9 = (CFG.modul == UBFF_MOD_QAM16) ? ({1'b0, CFG.guard_sym} + 9'h001) >> 1
                                                           : ({1'b0, CFG.guard_sym} + 9'h003) >> 2;
  wire logic [UBFF_CNT_W-1:0] ovh_b = UBFF_CNT_W'(guard_b9) + UBFF_CNT_W'(CFG.preamble);
  wire logic [UBFF_CNT_W-1:0] rem0  = (grant_b > ovh_b) ? grant_b - ovh_b : '0;
  wire logic cfg_ok   = CFG.k >= UBFF_MIN_INFO;
  wire logic cfg_take = CFG_VALID & (st_q == UBFF_ST_IDLE);

  // Codeword planning at each codeword boundary
  wire logic [UBFF_CNT_W-1:0] par_w = UBFF_CNT_W'(cfg_q.parity);
  wire logic [UBFF_CNT_W-1:0] avail = (rem_q >= par_w) ? rem_q - par_w : '0;
  wire logic full_fit  = avail >= UBFF_CNT_W'(cfg_q.k);
  wire logic short_fit = (cfg_q.cw_mode == UBFF_CW_SHORT) & (avail >= UBFF_CNT_W'(UBFF_MIN_INFO));
  wire logic plan_go   = full_fit | short_fit;
  wire logic [7:0] plan_len = full_fit ? cfg_q.k : avail[7:0];

  // Byte stream feeding the mapper
  wire logic tx_on   = (st_q != UBFF_ST_IDLE) & (st_q != UBFF_ST_WAIT);
  wire logic emit_st = (st_q == UBFF_ST_PRE) | (st_q == UBFF_ST_INFO) | (st_q == UBFF_ST_PAR);
  wire logic take    = sym_en & emit_st & (bl_q == 4'h0);
  wire logic in_info = st_q == UBFF_ST_INFO;
  wire logic want    = take & in_info & ~done_q;
  wire logic got     = want & S_VALID;
  wire logic last_in = got & S_LAST;
  wire logic data_end = done_q | last_in;
  wire logic [7:0] raw_b = (st_q == UBFF_ST_PRE) ? PRE_BYTE : (got ? S_DATA : UBFF_ZERO);

  function automatic logic [UBFF_SCR_W+7:0] scr_step(input logic [UBFF_SCR_W-1:0] s,
                                                      input logic [7:0] d);
    logic [UBFF_SCR_W-1:0] t;
    logic [7:0]            o;
    logic                  fb;
    t = s;
    o = d;
    for (int i = 7; i >= 0; i--)
    begin
      fb   = ^(t & SCR_TAPS);
      o[i] = d[i] ^ fb;
      t    = {t[UBFF_SCR_W-2:0], fb};
    end
    return {t, o};
  endfunction : scr_step

  wire logic [UBFF_SCR_W+7:0] scr_r = scr_step(scr_q, raw_b);
  wire logic scr_on = st_q != UBFF_ST_PRE;
  wire logic [7:0] tx_byte = scr_on ? scr_r[7:0] : raw_b;

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencing
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      UBFF_ST_IDLE:
        if (cfg_take & cfg_ok)
          st_d = UBFF_ST_WAIT;
      UBFF_ST_WAIT:
        if (sym_en & (sym_cnt_q == cfg_q.launch))
          st_d = (cfg_q.preamble != UBFF_ZERO) ? UBFF_ST_PRE
               : (cfg_q.fec_en ? UBFF_ST_PLAN : UBFF_ST_INFO);
      UBFF_ST_PRE:
        if (take & (left_q == 8'h01))
          st_d = cfg_q.fec_en ? UBFF_ST_PLAN : UBFF_ST_INFO;
      UBFF_ST_PLAN:
        st_d = plan_go ? UBFF_ST_INFO : UBFF_ST_DRAIN;
      UBFF_ST_INFO:
        if (take & ~cfg_q.fec_en & data_end)
          st_d = UBFF_ST_DRAIN;
        else if (take & cfg_q.fec_en & (left_q == 8'h01))
          st_d = (cfg_q.parity != UBFF_ZERO) ? UBFF_ST_PAR : UBFF_ST_PLAN;
      UBFF_ST_PAR:
        if (take & (left_q == 8'h01))
          st_d = UBFF_ST_PLAN;
      UBFF_ST_DRAIN:
        if (sym_en & (bl_q == 4'h0))
          st_d = UBFF_ST_IDLE;
      default:
        st_d = UBFF_ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q   <= UBFF_ST_IDLE;
      cfg_q  <= '0;
      rem_q  <= '0;
      left_q <= '0;
      done_q <= 1'b0;
      scr_q  <= '0;
    end
    else
    begin
      st_q <= st_d;
      if (cfg_take)
      begin
        cfg_q  <= CFG;
        rem_q  <= rem0;
        left_q <= CFG.preamble;
        done_q <= 1'b0;
        scr_q  <= SCR_SEED;
      end
      else
      begin
        if (last_in)
          done_q <= 1'b1;
        if (take & scr_on)
          scr_q <= scr_r[UBFF_SCR_W+7:8];
        if (take & (st_q != UBFF_ST_PRE) & (rem_q != '0))
          rem_q <= rem_q - 1'b1;
        if (st_q == UBFF_ST_PLAN)
          left_q <= plan_len;
        else if (take & in_info & (left_q == 8'h01))
          left_q <= cfg_q.parity;
        else if (take)
          left_q <= left_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Symbol mapper
  wire logic       qam   = cfg_q.modul == UBFF_MOD_QAM16;
  wire logic [3:0] bps   = qam ? UBFF_BPS_QAM : UBFF_BPS_QPSK;
  wire logic [7:0] cur_b = (bl_q == 4'h0) ? tx_byte : sh_q;
  wire logic sym_act = take | (sym_en & (bl_q != 4'h0));

  function automatic logic signed [UBFF_SYM_W-1:0] lvl16(input logic [1:0] b);
    case (b)
      2'b00:   return UBFF_LVL_P3;
      2'b01:   return UBFF_LVL_P1;
      2'b11:   return -UBFF_LVL_P1;
      default: return -UBFF_LVL_P3;
    endcase
  endfunction : lvl16

  wire logic signed [UBFF_SYM_W-1:0] sym_i = qam ? lvl16(cur_b[7:6])
                                           : (cur_b[7] ? -UBFF_LVL_P2 : UBFF_LVL_P2);
  wire logic signed [UBFF_SYM_W-1:0] sym_q = qam ? lvl16(cur_b[5:4])
                                           : (cur_b[6] ? -UBFF_LVL_P2 : UBFF_LVL_P2);
  wire logic signed [UBFF_SYM_W-1:0] fir_i = sym_act ? sym_i : UBFF_LVL_0;
  wire logic signed [UBFF_SYM_W-1:0] fir_q = sym_act ? sym_q : UBFF_LVL_0;

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= '0;
      bl_q <= '0;
    end
    else if (sym_act)
    begin
      sh_q <= cur_b << bps;
      bl_q <= ((bl_q == 4'h0) ? UBFF_BYTE_BITS : bl_q) - bps;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and shaping
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CFG_ERR  <= 1'b0;
      UNDERRUN <= 1'b0;
      OVERRUN  <= 1'b0;
    end
    else
    begin
      CFG_ERR <= cfg_take & ~cfg_ok;
      if (want & ~S_VALID)
        UNDERRUN <= 1'b1;
      else if (cfg_take)
        UNDERRUN <= 1'b0;
      if ((st_q == UBFF_ST_PLAN) & ~plan_go & ~done_q)
        OVERRUN <= 1'b1;
      else if (cfg_take)
        OVERRUN <= 1'b0;
    end
  end

  assign CFG_READY = st_q == UBFF_ST_IDLE;
  assign S_READY   = want;
  assign TX_ON     = tx_on;

  ubff_srrc #(
    .TAPS   (UBFF_TAPS),
    .IN_W   (UBFF_SYM_W),
    .COEF_W (UBFF_COEF_W),
    .OUT_W  (OUT_W)
  ) u_srrc (
    .clk       (REF_CLK),
    .rst_n     (rst_n),
    .in_valid  (sample_en),
    .in_i      (fir_i),
    .in_q      (fir_q),
    .out_i     (TX_I),
    .out_q     (TX_Q),
    .out_valid (TX_VALID)
  );

endmodule : ubff_framer

// ==== testbench/ubff_chk.sv ====
// Port checker of the burst framer
`timescale 1ns/10ps
module ubff_chk (
  input wire logic                REF_CLK,
  input wire logic                NRST,
  input wire ubff_pkg::ubff_cfg_t CFG,
  input wire logic                CFG_VALID,
  input wire logic                CFG_READY,
  input wire logic                CFG_ERR,
  input wire logic                S_VALID,
  input wire logic                S_READY,
  input wire logic                TX_VALID,
  input wire logic                TX_ON,
  input wire logic                UNDERRUN,
  input wire logic                OVERRUN
);
  import ubff_pkg::*;
  wire take = CFG_VALID && CFG_READY;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////
  cfg_refuse_a: assert property (take && CFG.k < UBFF_MIN_INFO |=> CFG_ERR && CFG_READY)
    else $error("short k not refused");
  cfg_take_a: assert property (take && CFG.k >= UBFF_MIN_INFO |=> !CFG_READY && !CFG_ERR && !UNDERRUN && !OVERRUN)
    else $error("config take wrong");
  err_cause_a: assert property (CFG_ERR |-> $past(take && CFG.k < UBFF_MIN_INFO))
    else $error("error pulse without cause");
  byte_space_a: assert property (S_READY |=> !S_READY [*7])
    else $error("bytes too close");
  byte_burst_a: assert property (S_READY |-> TX_ON && !CFG_READY)
    else $error("byte taken outside burst");
  burst_busy_a: assert property (TX_ON |-> !CFG_READY)
    else $error("ready during burst");
  under_set_a: assert property (S_READY && !S_VALID |=> UNDERRUN)
    else $error("underrun not flagged");
  under_hold_a: assert property (UNDERRUN && !take |=> UNDERRUN)
    else $error("underrun lost");
  over_burst_a: assert property ($rose(OVERRUN) |-> !CFG_READY)
    else $error("overrun outside burst");
  sample_pulse_a: assert property (TX_VALID |=> !TX_VALID)
    else $error("sample strobe too long");
  cover property (CFG_ERR);
  cover property ($rose(OVERRUN));
  cover property ($rose(UNDERRUN));
  cover property ($fell(TX_ON));
endmodule : ubff_chk

bind ubff_framer ubff_chk u_chk (.REF_CLK(REF_CLK), .NRST(NRST), .CFG(CFG), .CFG_VALID(CFG_VALID),
  .CFG_READY(CFG_READY), .CFG_ERR(CFG_ERR), .S_VALID(S_VALID), .S_READY(S_READY), .TX_VALID(TX_VALID),
  .TX_ON(TX_ON), .UNDERRUN(UNDERRUN), .OVERRUN(OVERRUN));

// ==== testbench/ubff_mac_src.sv ====
// Byte source standing in for the MAC side
`timescale 1ns/10ps
module ubff_mac_src (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [15:0] len,
  input  wire logic [15:0] gap,
  input  wire logic        s_ready,
  output logic [7:0]       s_data,
  output logic             s_valid,
  output logic             s_last,
  output logic [15:0]      taken
);
  logic [15:0] idx_q;
  logic        miss_q;
  ////////////////////////////////////////
  // Valid drops once at the gap byte
  assign s_valid = idx_q < len && !(idx_q == gap && !miss_q);
  assign s_last  = s_valid && idx_q == len - 16'h0001;
  // Idle data is the inverse of the last byte
  assign s_data  = s_valid ? idx_q[7:0] + 8'h01 : ~idx_q[7:0];
  assign taken   = idx_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      idx_q  <= '0;
      miss_q <= 1'b0;
    end
    else if (load)
    begin
      idx_q  <= '0;
      miss_q <= 1'b0;
    end
    else if (s_ready && s_valid)
      idx_q <= idx_q + 16'h0001;
    else if (s_ready)
      miss_q <= 1'b1;
endmodule : ubff_mac_src

// ==== testbench/ubff_framer_bench.sv ====
// Self-checking bench of the burst framer
`timescale 1ns/10ps
module ubff_framer_bench;
  import ubff_pkg::*;
  localparam int SD = 4;
  logic        ref_clk, nrst, cfg_valid, ld, cfg_ready, cfg_err, s_valid, s_last, s_ready;
  logic        tx_valid, tx_on, under, over;
  logic [7:0]  s_data;
  logic [15:0] src_len, src_gap, taken;
  logic signed [15:0] tx_i, tx_q;
  ubff_cfg_t   cfg;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // One symbol from TX_ON rising to the first byte taken
  int          base = SD;
  ////////////////////////////////////////
  ubff_framer #(.SYM_DIV(SD), .PRE_BYTE(8'hcc)) dut (.REF_CLK(ref_clk), .NRST(nrst), .CFG(cfg), .CFG_VALID(cfg_valid),
    .CFG_READY(cfg_ready), .CFG_ERR(cfg_err), .S_DATA(s_data), .S_VALID(s_valid), .S_LAST(s_last),
    .S_READY(s_ready), .TX_I(tx_i), .TX_Q(tx_q), .TX_VALID(tx_valid), .TX_ON(tx_on), .UNDERRUN(under),
    .OVERRUN(over));
  ubff_mac_src src (.clk(ref_clk), .rst_n(nrst), .load(ld), .len(src_len), .gap(src_gap),
    .s_ready(s_ready), .s_data(s_data), .s_valid(s_valid), .s_last(s_last), .taken(taken));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic give_up;
    bad_count++;
    $display("ERROR %0t: wait ran out", $time);
    end_of_test;
  endtask : give_up
  // One burst; len is the TX_ON time in clocks
  task automatic burst(input logic fec, input ubff_cwmode_t md, input ubff_mod_t mo, input logic [7:0] gms,
    input logic [7:0] msb, input logic [15:0] nb, input logic [15:0] gp, output int len, output int dly);
    int n;
    int ei;
    int eq;
    len = 0;
    dly = 0;
    n = 0;
    cfg = '{fec, md, mo, 8'h20, 8'h04, 8'h08, gms, msb, 8'h02, 16'((cyc - 12) / SD + 30)};
    src_len = nb;
    src_gap = gp;
    cfg_valid = 1'b1;
    @(posedge ref_clk);
    #1 cfg_valid = 1'b0;
    ld = 1'b1;
    @(posedge ref_clk);
    #1 ld = 1'b0;
    while (tx_on !== 1'b1 && dly < 4000)
    begin
      @(posedge ref_clk);
      #1 dly++;
    end
    // First preamble symbol of byte cc reaches the first tap output
    repeat (SD + SD / 2) @(posedge ref_clk);
    #1 len = SD + SD / 2;
    ei = (mo == UBFF_MOD_QAM16) ? -1 : -2;
    eq = (mo == UBFF_MOD_QAM16) ? 3 : -2;
    check(tx_valid, 1'b1);
    check(tx_i, ei * UBFF_SRRC_COEF[0]);
    check(tx_q, eq * UBFF_SRRC_COEF[0]);
    while (tx_on === 1'b1 && len < 9000)
    begin
      @(posedge ref_clk);
      #1 len++;
    end
    while (cfg_ready !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (dly >= 4000 || len >= 9000 || n >= 100)
      give_up;
  endtask : burst
  ////////////////////////////////////////
  task automatic t_refuse;
    cfg = '{1'b0, UBFF_CW_FIXED, UBFF_MOD_QPSK, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000};
    cfg_valid = 1'b1;
    @(posedge ref_clk);
    #1 cfg_valid = 1'b0;
    check(cfg_err, 1'b1);
    check(cfg_ready, 1'b1);
    @(posedge ref_clk);
    #1 check(cfg_err, 1'b0);
  endtask : t_refuse
  // Room for one full codeword only; data is cut
  task automatic t_fixed;
    int len, dly;
    burst(1'b1, UBFF_CW_FIXED, UBFF_MOD_QPSK, 8'h08, 8'h08, 16'h0028, 16'hffff, len, dly);
    check(len, base + 38 * 4 * SD);
    check(taken, 32'h20);
    check(over, 1'b1);
    check(dly >= 100 && dly <= 132, 1'b1);
  endtask : t_fixed
  // Same grant, shortened last codeword of twenty bytes
  task automatic t_short;
    int len, dly;
    burst(1'b1, UBFF_CW_SHORT, UBFF_MOD_QPSK, 8'h08, 8'h08, 16'h0028, 16'hffff, len, dly);
    check(taken, 32'h28);
    check(over, 1'b0);
    check(len, base + 62 * 4 * SD);
  endtask : t_short
  // Fourteen bytes left after one codeword; grant sized for the data
  task automatic t_omit;
    int len, dly;
    burst(1'b1, UBFF_CW_SHORT, UBFF_MOD_QPSK, 8'h1d, 8'h02, 16'h0014, 16'hffff, len, dly);
    check(taken, 32'h14);
    check(len, base + 38 * 4 * SD);
  endtask : t_omit
  // Two codewords, the second all zero
  task automatic t_zero_cw;
    int len, dly;
    burst(1'b1, UBFF_CW_FIXED, UBFF_MOD_QAM16, 8'h0d, 8'h06, 16'h0005, 16'hffff, len, dly);
    check(taken, 32'h05);
    check(len, base + 74 * 2 * SD);
  endtask : t_zero_cw
  // Coding off, source starved once
  task automatic t_bypass;
    int len, dly;
    burst(1'b0, UBFF_CW_FIXED, UBFF_MOD_QAM16, 8'h01, 8'h01, 16'h000a, 16'h0003, len, dly);
    check(taken, 32'h0a);
    check(under, 1'b1);
    check(len, base + 13 * 2 * SD);
  endtask : t_bypass
  ////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    cfg_valid = 1'b0;
    ld = 1'b0;
    src_len = '0;
    src_gap = 16'hffff;
    cfg = '0;
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    t_refuse;
    t_fixed;
    t_short;
    t_omit;
    t_zero_cw;
    t_bypass;
    end_of_test;
  end
endmodule : ubff_framer_bench
